// file: logic/pc_flag_bank_and_call_stack.sv
// Program counter, mode-banked carry/zero flags and six-level return stack
`timescale 1ns/10ps
`include "pc_stack_defs.svh"
module pc_flag_bank_and_call_stack #(
    parameter int DEPTH   = `STACK_DEPTH,
    parameter int DIVIDER = `CPU_CLK_DIV
) (
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_n_i,
    // Sequencer requests
    input  wire pc_stack_pkg::seq_req_t     req_i,
    input  wire logic [7:0]                 branch_offset_i,
    // Flag updates
    input  wire pc_stack_pkg::flag_upd_t    flag_upd_i,
    // State outputs
    output logic [`PC_WIDTH-1:0]            pc_o,
    output logic                            cpu_cycle_o,
    output pc_stack_pkg::cpu_mode_t         mode_o,
    output logic                            active_carry_o,
    output logic                            active_zero_o,
    output logic                            normal_mode_carry_o,
    output logic                            normal_mode_zero_o,
    output logic                            irq_mode_carry_o,
    output logic                            irq_mode_zero_o,
    output logic                            nmi_mode_carry_o,
    output logic                            nmi_mode_zero_o,
    output logic [2:0]                      stack_level_o,
    output logic                            stack_empty_o,
    output logic                            stack_full_o
);
    import pc_stack_pkg::*;

    // ----------------------------------------------------------------
    // CPU cycle divider
    // ----------------------------------------------------------------
    logic [`DIV_CNT_W-1:0] div_q;
    logic [`DIV_CNT_W-1:0] div_d;
    wire                   cyc_end = (div_q == `DIV_CNT_W'(DIVIDER - 1));

    assign div_d = cyc_end ? '0 : div_q + `DIV_CNT_W'(1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // Registered strobe so consumers see a clean one-cycle pulse
    logic cyc_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_q <= 1'b0;
        end else begin
            cyc_q <= cyc_end;
        end
    end
    wire cyc_en = cyc_q;
    assign cpu_cycle_o = cyc_q;

    // ----------------------------------------------------------------
    // Return stack and program counter
    // ----------------------------------------------------------------
    // Only addresses are held here; data registers are software's job
    logic [`PC_WIDTH-1:0] stack_q [DEPTH];
    logic [`PC_WIDTH-1:0] pc_q;
    logic [`PC_WIDTH-1:0] pc_d;
    logic [2:0]           lvl_q;
    logic [2:0]           lvl_d;

    wire do_push = req_i.call_push | req_i.irq_enter | req_i.nmi_enter;
    wire do_pop  = req_i.sub_exit | req_i.int_exit;
    wire empty   = (lvl_q == 3'h0);
    wire full    = (lvl_q == 3'(DEPTH));

    function automatic logic [`PC_WIDTH-1:0] pc_add(input logic [`PC_WIDTH-1:0] a,
                                                    input logic [7:0] off);
        logic [`PC_WIDTH-1:0] ext;
        ext = {{(`PC_WIDTH-8){off[7]}}, off};
        pc_add = a + ext;
    endfunction : pc_add

    // Interrupt entry takes priority over a concurrent increment
    assign pc_d = (do_push | req_i.jump_load) ? req_i.target :
                  (do_pop && !empty)          ? stack_q[0] :
                  (do_pop && empty)           ? pc_add(pc_q, 8'h01) :
                  req_i.branch_add            ? pc_add(pc_q, branch_offset_i) :
                  req_i.incr                  ? pc_q + `PC_STEP :
                  pc_q;

    assign lvl_d = (do_push && !full) ? lvl_q + 3'h1 :
                   (do_pop && !empty) ? lvl_q - 3'h1 :
                   lvl_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_q  <= `RESET_VECTOR;
            lvl_q <= 3'h0;
        end else if (cyc_en) begin
            pc_q  <= pc_d;
            lvl_q <= lvl_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stack_q[i] <= '0;
            end
        end else if (cyc_en && do_push) begin
            // Stack receives the address to resume at
            stack_q[0] <= pc_q;
            for (int i = 1; i < DEPTH; i++) begin
                stack_q[i] <= stack_q[i-1];
            end
        end else if (cyc_en && do_pop && !empty) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                stack_q[i] <= stack_q[i+1];
            end
            stack_q[DEPTH-1] <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Mode tracking and flag bank
    // ----------------------------------------------------------------
    // Previous mode of the two innermost interrupt nestings kept in a two-entry mode stack
    cpu_mode_t mode_q;
    cpu_mode_t mode_d;
    cpu_mode_t prev_q [2];

    assign mode_d = req_i.nmi_enter ? MODE_NMI :
                    req_i.irq_enter ? MODE_IRQ :
                    req_i.int_exit  ? prev_q[0] :
                    mode_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q    <= MODE_NMI;
            prev_q[0] <= MODE_NORMAL;
            prev_q[1] <= MODE_NORMAL;
        end else if (cyc_en) begin
            mode_q <= mode_d;
            if (req_i.nmi_enter || req_i.irq_enter) begin
                prev_q[0] <= mode_q;
                prev_q[1] <= prev_q[0];
            end else if (req_i.int_exit) begin
                prev_q[0] <= prev_q[1];
                prev_q[1] <= MODE_NORMAL;
            end
        end
    end

    flag_pair_t bank_q [3];
    flag_pair_t act;
    flag_pair_t act_d;

    assign act = bank_q[mode_q];
    assign act_d.carry = flag_upd_i.bit_test_we ? flag_upd_i.tested_bit :
                         flag_upd_i.arith_we    ? flag_upd_i.arith_carry :
                         flag_upd_i.carry_we    ? flag_upd_i.carry_val :
                         act.carry;
    assign act_d.zero  = (flag_upd_i.arith_we | flag_upd_i.logic_we) ?
                         flag_upd_i.result_zero : act.zero;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 3; i++) begin
                bank_q[i] <= '0;
            end
        end else if (cyc_en) begin
            // Only the owning pair is written; others hold across switches
            bank_q[mode_q] <= act_d;
        end
    end

    assign pc_o                = pc_q;
    assign mode_o              = mode_q;
    assign active_carry_o      = act.carry;
    assign active_zero_o       = act.zero;
    assign normal_mode_carry_o = bank_q[MODE_NORMAL].carry;
    assign normal_mode_zero_o  = bank_q[MODE_NORMAL].zero;
    assign irq_mode_carry_o    = bank_q[MODE_IRQ].carry;
    assign irq_mode_zero_o     = bank_q[MODE_IRQ].zero;
    assign nmi_mode_carry_o    = bank_q[MODE_NMI].carry;
    assign nmi_mode_zero_o     = bank_q[MODE_NMI].zero;
    assign stack_level_o       = lvl_q;
    assign stack_empty_o       = empty;
    assign stack_full_o        = full;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_cyc_push;
        cyc_en && do_push;
    endsequence

    property p_pc_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !cyc_en |=> $stable(pc_q);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved off cycle");

    property p_incr;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && req_i.incr && !do_push && !do_pop && !req_i.jump_load && !req_i.branch_add
        |=> pc_q == $past(pc_q) + `PC_STEP;
    endproperty
    a_incr: assert property (p_incr) else $error("increment wrong");

    property p_push;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_cyc_push |=> stack_q[0] == $past(pc_q) && pc_q == $past(req_i.target);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");

    property p_pop;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && do_pop && !do_push && !empty |=> pc_q == $past(stack_q[0]);
    endproperty
    a_pop: assert property (p_pop) else $error("pop wrong");

    property p_sat;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_cyc_push ##0 full |=> lvl_q == 3'(DEPTH);
    endproperty
    a_sat: assert property (p_sat) else $error("stack not saturated");

    property p_empty_pop;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && do_pop && !do_push && empty |=> lvl_q == 3'h0;
    endproperty
    a_empty_pop: assert property (p_empty_pop) else $error("empty pop moved level");

    property p_nmi_mode;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && req_i.nmi_enter |=> mode_q == MODE_NMI;
    endproperty
    a_nmi_mode: assert property (p_nmi_mode) else $error("nmi mode missed");

    property p_irq_mode;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && req_i.irq_enter && !req_i.nmi_enter |=> mode_q == MODE_IRQ;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq mode missed");

    property p_branch;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_en && req_i.branch_add && !do_push && !do_pop && !req_i.jump_load
        |=> pc_q == $past(pc_q) + {{(`PC_WIDTH-8){$past(branch_offset_i[7])}},
                                    $past(branch_offset_i)};
    endproperty
    a_branch: assert property (p_branch) else $error("branch sum wrong");

    property p_other_bank;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_q != MODE_NORMAL |=> $stable(bank_q[MODE_NORMAL]);
    endproperty
    a_other_bank: assert property (p_other_bank) else $error("foreign bank changed");

    // Clocks since the last strobe; a counter keeps the check cheap to unroll
    logic [7:0] gap_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= cyc_q ? 8'h01 : gap_q + 8'h01;
        end
    end

    property p_div;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        cyc_q |-> gap_q == 8'(DIVIDER);
    endproperty
    a_div: assert property (p_div) else $error("cycle period wrong");

    property p_div_gap;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        gap_q <= 8'(DIVIDER);
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("cycle strobe missing");
endmodule : pc_flag_bank_and_call_stack

// file: logic/pc_stack_defs.svh
// Constants for the program counter, flag bank and return stack
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH
`define PC_WIDTH        12
`define STACK_DEPTH     6
`define CPU_CLK_DIV     13
`define RESET_VECTOR    12'hffe
`define PC_STEP         12'h001
`define DIV_CNT_W       4
`endif

// file: logic/pc_stack_pkg.sv
// Types shared by the program counter, flag bank and return stack
`include "pc_stack_defs.svh"
package pc_stack_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_IRQ,
        MODE_NMI
    } cpu_mode_t;

    typedef struct packed {
        logic carry;
        logic zero;
    } flag_pair_t;

    // Sequencer requests for one CPU cycle
    typedef struct packed {
        logic                   incr;
        logic                   branch_add;
        logic                   jump_load;
        logic                   call_push;
        logic                   irq_enter;
        logic                   nmi_enter;
        logic                   sub_exit;
        logic                   int_exit;
        logic [`PC_WIDTH-1:0]   target;
    } seq_req_t;

    // Flag update from the arithmetic unit
    typedef struct packed {
        logic   arith_we;
        logic   arith_carry;
        logic   logic_we;
        logic   result_zero;
        logic   bit_test_we;
        logic   tested_bit;
        logic   carry_we;
        logic   carry_val;
    } flag_upd_t;
endpackage : pc_stack_pkg

// file: verif/seq_model.sv
// Sequencer model: one request per CPU cycle, set and released on falling edges
`timescale 1ns/10ps
module seq_model
    import pc_stack_pkg::*;
(
    // Clock and strobe
    input  wire logic                   sys_clk_i,
    input  wire logic                   cpu_cycle_i,
    // Requests towards the block
    output pc_stack_pkg::seq_req_t      req_o,
    output pc_stack_pkg::flag_upd_t     upd_o,
    output logic [7:0]                  off_o
);
    initial begin
        req_o = '0;
        upd_o = '0;
        off_o = 8'h00;
    end

    // Returns on the falling edge just before a CPU-cycle sample
    task automatic wait_cyc();
        int n;
        n = 0;
        while (cpu_cycle_i !== 1'b1) begin
            @(negedge sys_clk_i);
            n++;
            if (n > 40) begin
                testbench.miscompares++;
                testbench.wrap_up();
            end
        end
    endtask : wait_cyc

    task automatic issue(input int k, input logic [11:0] t, input logic [7:0] off,
                         input flag_upd_t f);
        seq_req_t r;
        r        = '0;
        r[k]     = 1'b1;
        r.target = t;
        wait_cyc();
        req_o    = r;
        upd_o    = f;
        off_o    = off;
        @(negedge sys_clk_i);
        // Released lines show garbage, not the last value
        r        = '0;
        r.target = ~t;
        req_o    = r;
        upd_o    = '0;
        off_o    = ~off;
        wait_cyc();
    endtask : issue
endmodule : seq_model

// file: verif/testbench.sv
// Self-checking bench for the program counter, flag bank and return stack
`timescale 1ns/10ps
module testbench;
    import pc_stack_pkg::*;
    localparam int INC = 19, BRA = 18, JMP = 17, CALL = 16;
    localparam int IRQ = 15, NMI = 14, SUBX = 13, INTX = 12;
    logic               sys_clk_i, reset_n_i, cyc, ac, az, nc, nz, ic, iz, mc, mz, emp, full;
    logic [11:0]        pc_o, epc;
    logic [2:0]         lvl;
    cpu_mode_t          mode_o;
    seq_req_t           req;
    flag_upd_t          upd;
    logic [7:0]         off;
    logic [11:0]        stk[$];
    int                 miscompares, n_tests;

    pc_flag_bank_and_call_stack uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .req_i(req), .branch_offset_i(off), .flag_upd_i(upd), .pc_o(pc_o),
        .cpu_cycle_o(cyc), .mode_o(mode_o), .active_carry_o(ac), .active_zero_o(az),
        .normal_mode_carry_o(nc), .normal_mode_zero_o(nz), .irq_mode_carry_o(ic),
        .irq_mode_zero_o(iz), .nmi_mode_carry_o(mc), .nmi_mode_zero_o(mz),
        .stack_level_o(lvl), .stack_empty_o(emp), .stack_full_o(full));
    seq_model sm (.sys_clk_i(sys_clk_i), .cpu_cycle_i(cyc), .req_o(req), .upd_o(upd),
        .off_o(off));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // --------------------------------------------------------------
    // Compare, operate, close
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Branch offsets travel in the low byte of t
    task automatic op(input int k, input logic [11:0] t, input flag_upd_t f = '0);
        sm.issue(k, t, t[7:0], f);
        case (k)
            INC: epc = epc + 12'h001;
            BRA: epc = epc + {{4{t[7]}}, t[7:0]};
            JMP: epc = t;
            CALL, IRQ, NMI: begin
                stk.push_front(epc);
                if (stk.size() > 6) void'(stk.pop_back());
                epc = t;
            end
            default: epc = (stk.size() > 0) ? stk.pop_front() : epc + 12'h001;
        endcase
        chk("pc", pc_o, epc);
        chk("level", lvl, 16'(stk.size()));
        chk("full", full, 16'(stk.size() == 6));
        chk("empty", emp, 16'(stk.size() == 0));
    endtask : op

    task automatic pair(input cpu_mode_t m, input logic [5:0] nim, input logic [1:0] act);
        chk("mode", mode_o, m);
        chk("banks", {nc, nz, ic, iz, mc, mz}, nim);
        chk("active", {ac, az}, act);
    endtask : pair

    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        int n;
        reset_n_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk("cyc", cyc, 1'b0);
        reset_n_i = 1'b1;
        epc = 12'hffe;
        chk("pc", pc_o, 16'hffe);
        chk("empty", emp, 1'b1);
        pair(MODE_NMI, 6'h00, 2'b00);
        sm.wait_cyc();
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (cyc !== 1'b1 && n < 40);
        chk("period", 16'(n), 16'd13);
        op(INC, 12'h000);
        op(INC, 12'h000);
        op(JMP, 12'h100);
        op(BRA, 12'h005);
        op(BRA, 12'h0fd);
        op(INC, 12'h000, 8'hf0);
        pair(MODE_NMI, 6'h03, 2'b11);
        op(INC, 12'h000, 8'hd8);
        pair(MODE_NMI, 6'h01, 2'b01);
        op(INC, 12'h000, 8'hd0);
        op(INTX, 12'h000);
        pair(MODE_NORMAL, 6'h03, 2'b00);
        op(INC, 12'h000, 8'he0);
        pair(MODE_NORMAL, 6'h23, 2'b10);
        for (int i = 0; i < 5; i++) op(CALL, 12'h200 + 12'(i));
        op(IRQ, 12'h3f0);
        pair(MODE_IRQ, 6'h23, 2'b00);
        op(INC, 12'h000, 8'h03);
        op(NMI, 12'h3fc);
        pair(MODE_NMI, 6'h2b, 2'b11);
        op(INTX, 12'h000);
        pair(MODE_IRQ, 6'h2b, 2'b10);
        op(INTX, 12'h000);
        pair(MODE_NORMAL, 6'h2b, 2'b10);
        for (int i = 0; i < 5; i++) op(SUBX, 12'h000);
        op(CALL, 12'h222);
        reset_n_i = 1'b0;
        @(negedge sys_clk_i);
        chk("pc", pc_o, 16'hffe);
        chk("level", lvl, 3'd0);
        pair(MODE_NMI, 6'h00, 2'b00);
        reset_n_i = 1'b1;
        wrap_up();
    end
endmodule : testbench
